// ===== rtl/comma_lock_pkg.sv
package comma_lock_pkg;

  // register offsets on the channel register port
  localparam logic [7:0] WINDOW_CFG_ADDR = 8'h90;  // comma_window_and_count_high
  localparam logic [7:0] MIN_LOW_ADDR    = 8'h91;  // comma_min_count_low
  localparam logic [7:0] SPARE_A_ADDR    = 8'h92;  // spare_reg_a
  localparam logic [7:0] SPARE_B_ADDR    = 8'h93;  // spare_reg_b

  // reset values
  localparam logic [7:0] WINDOW_CFG_RST = 8'h00;
  localparam logic [7:0] MIN_LOW_RST    = 8'h00;
  localparam logic [7:0] SPARE_RST      = 8'h00;

  // field positions inside the window configuration register
  localparam int EXP_MSB     = 7;  // comma_window_exponent [7:4]
  localparam int EXP_LSB     = 4;
  localparam int MIN_HI_MSB  = 3;  // comma_min_count [11:8]
  localparam int MIN_HI_LSB  = 0;

  // window sizing: bits = base << exponent
  localparam int BASE_SHIFT  = 5;  // 32 bits at exponent zero
  localparam int BITCNT_W    = 21; // holds 32 * 2^15 bits
  localparam int HITCNT_W    = 12; // width of comma_min_count

  // register port request
  typedef struct packed {
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write data
    logic       wr;    // write strobe
    logic       rd;    // read strobe
  } regreq_type;

  // mode enables that live in other control registers
  typedef struct packed {
    logic commaLockEn;  // comma lock check mode
    logic sync66LockEn; // 64b/66b lock check mode
    logic lockIntrEn;   // comma or 64b/66b interrupt mode
    logic commaCheckEn; // comma counting enable
  } modes_type;

  // window sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_type;

endpackage : comma_lock_pkg

// ===== rtl/comma_lock_check_window.sv
module comma_lock_check_window (
  input  wire logic                      sys_clk,     // 100 MHz clock
  input  wire logic                      srst,        // sync reset, active high
  input  wire comma_lock_pkg::regreq_type regReq,     // register access request
  output logic [7:0]                     regRdData,   // read data, valid cycle after rd
  input  wire comma_lock_pkg::modes_type modes,       // mode enables from control regs
  input  wire logic                      bitStrobe,   // one received bit per pulse
  input  wire logic                      commaSeen,   // comma pattern detected pulse
  input  wire logic                      syncToggle,  // 64b/66b sync-header transition pulse
  output logic                           lockOk,      // last window qualified, level
  output logic                           windowEnd,   // window closed, one-cycle pulse
  output logic                           windowFail   // window closed below minimum, pulse
);

  // register storage
  // every byte here is plain read/write; the two spares are kept as storage
  // so that software scratch use reads back what it wrote
  logic [7:0] windowCfg_ff, nxt_windowCfg;   // exponent and count high nibble
  logic [7:0] minLow_ff,    nxt_minLow;      // count low byte
  logic [7:0] spareA_ff,    nxt_spareA;      // plain storage
  logic [7:0] spareB_ff,    nxt_spareB;      // plain storage
  logic [7:0] rdData_ff,    nxt_rdData;      // registered read answer

  // window state
  // the bit counter is sized for the longest window, 32 << 15 bits, so the
  // top exponent setting never wraps the count before the window closes
  comma_lock_pkg::state_type state_ff, nxt_state;  // sequencer
  logic [comma_lock_pkg::BITCNT_W-1:0] bitCnt_ff, nxt_bitCnt;  // bits seen in window
  logic [comma_lock_pkg::HITCNT_W-1:0] hitCnt_ff, nxt_hitCnt;  // detections in window
  logic lockOk_ff, nxt_lockOk;          // qualified status
  logic windowEnd_ff, nxt_windowEnd;    // end pulse
  logic windowFail_ff, nxt_windowFail;  // fail pulse

  // decoded settings
  // these are pure decodes of the register flops and the pins; they feed
  // the sequencer only, never an output, so no extra stage is needed
  logic [3:0]                          windowExp;   // comma_window_exponent
  logic [comma_lock_pkg::HITCNT_W-1:0] minCount;    // comma_min_count
  logic [comma_lock_pkg::BITCNT_W-1:0] lastBit;     // index of final bit in window
  logic                                anyMode;     // some check mode active
  logic                                hitEvent;    // qualifying detection this cycle
  logic [comma_lock_pkg::HITCNT_W-1:0] hitsNow;     // count including this cycle

  // settings decode
  // a new exponent or minimum takes effect at once: a write in mid-window
  // changes the current judgement instead of waiting for the next window
  always_comb begin
    windowExp = windowCfg_ff[comma_lock_pkg::EXP_MSB:comma_lock_pkg::EXP_LSB];
    minCount  = {windowCfg_ff[comma_lock_pkg::MIN_HI_MSB:comma_lock_pkg::MIN_HI_LSB], minLow_ff};
    // 32 << exp, minus one for a zero-based bit index; the shift is done
    // at full counter width so the largest exponent keeps its top bit
    lastBit   = (comma_lock_pkg::BITCNT_W'(1) << (comma_lock_pkg::BASE_SHIFT + int'(windowExp)))
                - comma_lock_pkg::BITCNT_W'(1);
    // any one of the three check modes keeps the window running; the
    // comma checking enable alone only gates counting, not the window
    anyMode   = modes.commaLockEn | modes.sync66LockEn | modes.lockIntrEn;
    // 64b/66b mode counts header transitions against the same settings;
    // it takes priority, and the comma checking enable does not gate it,
    // so a channel in 64b/66b lock check never mixes the two event kinds
    if (modes.sync66LockEn) begin
      hitEvent = syncToggle;
    end else begin
      hitEvent = commaSeen & modes.commaCheckEn;
    end
    // saturate so a long window never wraps back below the minimum;
    // the saturated count still meets even the largest minimum, and a
    // minimum of zero passes every window
    if (hitEvent && (hitCnt_ff != '1)) begin
      hitsNow = hitCnt_ff + comma_lock_pkg::HITCNT_W'(1);
    end else begin
      hitsNow = hitCnt_ff;
    end
  end

  // register write and read decode
  // writes to offsets outside the four bytes are dropped without effect;
  // a write and a read of one offset in the same cycle return the old byte
  always_comb begin
    nxt_windowCfg = windowCfg_ff;
    nxt_minLow    = minLow_ff;
    nxt_spareA    = spareA_ff;
    nxt_spareB    = spareB_ff;
    nxt_rdData    = rdData_ff;
    // write side: one offset per cycle, byte wide, no partial writes
    if (regReq.wr) begin
      if (regReq.addr == comma_lock_pkg::WINDOW_CFG_ADDR) begin
        nxt_windowCfg = regReq.wdata;
      end else if (regReq.addr == comma_lock_pkg::MIN_LOW_ADDR) begin
        nxt_minLow = regReq.wdata;
      end else if (regReq.addr == comma_lock_pkg::SPARE_A_ADDR) begin
        nxt_spareA = regReq.wdata;
      end else if (regReq.addr == comma_lock_pkg::SPARE_B_ADDR) begin
        nxt_spareB = regReq.wdata;
      end
    end
    // read answer holds until the next read
    // the answer is registered, so it appears the cycle after the strobe
    if (regReq.rd) begin
      if (regReq.addr == comma_lock_pkg::WINDOW_CFG_ADDR) begin
        nxt_rdData = windowCfg_ff;
      end else if (regReq.addr == comma_lock_pkg::MIN_LOW_ADDR) begin
        nxt_rdData = minLow_ff;
      end else if (regReq.addr == comma_lock_pkg::SPARE_A_ADDR) begin
        nxt_rdData = spareA_ff;
      end else if (regReq.addr == comma_lock_pkg::SPARE_B_ADDR) begin
        nxt_rdData = spareB_ff;
      end else begin
        // reads outside the four bytes return zero rather than stale data
        nxt_rdData = 8'h00; // unmapped offsets read zero
      end
    end
  end

  // register storage flops
  // synchronous reset returns every byte to its reset value
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      windowCfg_ff <= comma_lock_pkg::WINDOW_CFG_RST;
      minLow_ff    <= comma_lock_pkg::MIN_LOW_RST;
      spareA_ff    <= comma_lock_pkg::SPARE_RST;
      spareB_ff    <= comma_lock_pkg::SPARE_RST;
      // the read answer also clears, so a read right after reset sees zero
      rdData_ff    <= 8'h00;
    end else begin
      windowCfg_ff <= nxt_windowCfg;
      minLow_ff    <= nxt_minLow;
      spareA_ff    <= nxt_spareA;
      spareB_ff    <= nxt_spareB;
      rdData_ff    <= nxt_rdData;
    end
  end

  // window sequencer next state
  // pulses default low so they stand exactly one cycle; counters and the
  // lock level hold unless a branch below moves them
  // limitation: strobes in the cycle a mode first rises are not counted,
  // the first window starts one cycle later
  always_comb begin
    nxt_state      = state_ff;
    nxt_bitCnt     = bitCnt_ff;
    nxt_hitCnt     = hitCnt_ff;
    nxt_lockOk     = lockOk_ff;
    nxt_windowEnd  = 1'b0;
    nxt_windowFail = 1'b0;
    case (state_ff)
      comma_lock_pkg::ST_IDLE: begin
        // no mode enabled: nothing is judged, status stays clear
        // counters are held at zero so the next window starts clean
        nxt_bitCnt = '0;
        nxt_hitCnt = '0;
        nxt_lockOk = 1'b0;
        if (anyMode) begin
          nxt_state = comma_lock_pkg::ST_RUN;
        end
      end
      comma_lock_pkg::ST_RUN: begin
        // every mode dropped: abandon the window, clear the status
        if (!anyMode) begin
          nxt_state  = comma_lock_pkg::ST_IDLE;
          nxt_bitCnt = '0;
          nxt_hitCnt = '0;
          nxt_lockOk = 1'b0;
        end else if (bitStrobe && (bitCnt_ff >= lastBit)) begin
          // >= covers a shrink of the window mid-way; an event in this
          // closing cycle still counts, hence the judgement on hitsNow
          nxt_windowEnd  = 1'b1;
          nxt_lockOk     = (hitsNow >= minCount);
          nxt_windowFail = (hitsNow < minCount);
          nxt_bitCnt     = '0;
          nxt_hitCnt     = '0;
          // the next strobe is bit zero of the following window
        end else begin
          // inside the window: count events and received bits
          nxt_hitCnt = hitsNow;
          // only received bits advance the window, idle cycles do not
          if (bitStrobe) begin
            nxt_bitCnt = bitCnt_ff + comma_lock_pkg::BITCNT_W'(1);
          end
        end
      end
      default: begin
        // illegal code: fall back to idle, status cleared there
        nxt_state = comma_lock_pkg::ST_IDLE;
      end
    endcase
  end

  // window sequencer flops
  // reset leaves the sequencer idle with every status output low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff      <= comma_lock_pkg::ST_IDLE;
      bitCnt_ff     <= '0;
      hitCnt_ff     <= '0;
      lockOk_ff     <= 1'b0;
      windowEnd_ff  <= 1'b0;
      windowFail_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      bitCnt_ff     <= nxt_bitCnt;
      hitCnt_ff     <= nxt_hitCnt;
      lockOk_ff     <= nxt_lockOk;
      windowEnd_ff  <= nxt_windowEnd;
      windowFail_ff <= nxt_windowFail;
    end
  end

  // outputs straight from flops
  // lockOk is a level that stands until the next close or until every
  // mode drops; windowEnd and windowFail are single-cycle pulses
  // no output passes through logic between its flop and the port
  assign regRdData  = rdData_ff;
  assign lockOk     = lockOk_ff;
  assign windowEnd  = windowEnd_ff;
  assign windowFail = windowFail_ff;

endmodule : comma_lock_check_window

// ===== dv/comma_lock_check_window_sva.sv
module comma_lock_check_window_sva (
  input wire logic                       sys_clk,   // clock
  input wire logic                       srst,      // reset
  input wire comma_lock_pkg::regreq_type regReq,    // request
  input wire logic [7:0]                 regRdData, // read data
  input wire comma_lock_pkg::modes_type  modes,     // enables
  input wire logic                       lockOk,    // lock
  input wire logic                       windowEnd, // close
  input wire logic                       windowFail // fail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  wire logic act = |modes[3:1]; // any mode on
  // close and fail pulses agree with the lock level
  chk_fail_close: assert property (windowFail |-> windowEnd) else $error("fail without close");
  chk_pass_lock: assert property (windowEnd |-> lockOk != windowFail) else $error("bad lock");
  chk_close_once: assert property (windowEnd |=> !windowEnd) else $error("close twice");
  chk_idle_clear: assert property (!act |=> !lockOk && !windowEnd) else $error("idle lock");
  // lock may only move at a close or once idle
  chk_lock_hold: assert property (!windowEnd && $past(act) |-> $stable(lockOk)) else $error("lock moved");
  chk_unmapped_rd: assert property (regReq.rd && regReq.addr[7:2] != 6'h24 |=> regRdData == 8'h00)
    else $error("bad read");
  cov_pass: cover property (windowEnd && lockOk);
  cov_fail: cover property (windowFail);
  cov_sync: cover property (windowEnd && modes.sync66LockEn);
endmodule : comma_lock_check_window_sva

bind comma_lock_check_window comma_lock_check_window_sva chk (.sys_clk, .srst, .regReq,
  .regRdData, .modes, .lockOk, .windowEnd, .windowFail);

// ===== dv/comma_lock_check_window_tb.sv
module comma_lock_check_window_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       sys_clk = 1'b0;    // clock
  logic                       srst = 1'b1;       // reset
  comma_lock_pkg::regreq_type regReq = '0;       // request
  comma_lock_pkg::modes_type  modes = '0;        // enables
  logic                       bitStrobe = 1'b0;  // bit pulse
  logic                       commaSeen = 1'b0;  // comma pulse
  logic                       syncToggle = 1'b0; // sync pulse
  logic [7:0]                 regRdData;         // read data
  logic                       lockOk;            // lock
  logic                       windowEnd;         // close
  logic                       windowFail;        // fail
  logic                       rdLast = 1'b0;     // read taken
  logic [20:0]                strobes = '0;      // bits this window
  logic [23:0]                notes[$];          // expected, oldest first
  int                         errors = 0;        // mismatches
  int                         checksDone = 0;    // compares
  integer                     seed = 23802;      // random seed

  always #5 sys_clk = ~sys_clk; // 10 ns period

  comma_lock_check_window dut (.sys_clk, .srst, .regReq, .regRdData, .modes, .bitStrobe,
    .commaSeen, .syncToggle, .lockOk, .windowEnd, .windowFail);

  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // strobes taken while active, restarted after each close
  always @(posedge sys_clk) begin
    rdLast  <= regReq.rd;
    strobes <= ((windowEnd || !(|modes[3:1])) ? 21'h0 : strobes) + 21'(bitStrobe);
  end

  // outputs settle by the falling edge; take the oldest note
  always @(negedge sys_clk) begin
    if (rdLast) check("read", {16'h0, regRdData}, notes.pop_front());
    if (windowEnd) check("window", {1'b1, lockOk, windowFail, strobes}, notes.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk) regReq = '{a, d, 1'b1, 1'b0};
    @(negedge sys_clk) regReq = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    notes.push_back({16'h0, d});
    @(negedge sys_clk) regReq = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge sys_clk) regReq = '0;
  endtask : rd

  // two windows back to back; the unused event line is held high to show it is ignored
  task automatic win(input logic [3:0] m, input logic [3:0] e, input logic [11:0] mn, input int nEv);
    int   n;
    logic pass;
    n = 32 << e;
    pass = ((m[2] || m[0]) ? nEv : 0) >= mn;
    wr(8'h90, {e, mn[11:8]});
    wr(8'h91, mn[7:0]);
    rd(8'h90, {e, mn[11:8]});
    notes.push_back({1'b1, pass, !pass, 21'(n)});
    notes.push_back({1'b1, mn == 12'h000, mn != 12'h000, 21'(n)});
    @(negedge sys_clk) modes = m;
    // second window follows with no events: its count must restart at zero
    for (int i = 0; i < 2 * n; i++) begin
      @(negedge sys_clk) bitStrobe = 1'b1;
      commaSeen = m[2] || i < nEv;
      syncToggle = !m[2] || i < nEv;
    end
    @(negedge sys_clk) {bitStrobe, commaSeen, syncToggle} = 3'b000;
    repeat (2) @(negedge sys_clk);
    modes = '0;
    repeat (2) @(negedge sys_clk);
  endtask : win

  initial begin
    logic [31:0] r;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    wr(8'h94, 8'hFF);
    for (int a = 8'h90; a < 8'h95; a++) rd(8'(a), 8'h00);
    win(4'b1001, 4'h0, 12'h001, 1);
    win(4'b1001, 4'h1, 12'h003, 2);
    win(4'b1000, 4'h0, 12'h003, 5);
    win(4'b1001, 4'h2, 12'h100, 128);
    win(4'b0101, 4'h0, 12'h020, 32);
    win(4'b0101, 4'h0, 12'h020, 31);
    win(4'b0100, 4'h0, 12'h01F, 31);
    win(4'b0011, 4'h0, 12'h002, 1);
    repeat (3) begin
      r = $random(seed);
      win({r[0], ~r[0], 2'b01}, {2'b00, r[2:1]}, {7'h00, r[7:3]}, int'(r[13:8]) % 33);
    end
    check("pending", 24'(notes.size()), 24'h000000);
    stop_test();
  end

  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule : comma_lock_check_window_tb
